// ===== design/mdr_regs.svh
`ifndef MDR_REGS_SVH
`define MDR_REGS_SVH

// ==========================================================================
// Register offsets
`define MDR_OFS_STATUS     8'h10
`define MDR_OFS_SPEED_HI   8'h11
`define MDR_OFS_SPEED_LO   8'h12
`define MDR_OFS_PERIOD_HI  8'h13
`define MDR_OFS_PERIOD_LO  8'h14
`define MDR_OFS_KT_HI      8'h15
`define MDR_OFS_KT_LO      8'h16
`define MDR_OFS_CURR_HI    8'h17
`define MDR_OFS_CURR_LO    8'h18
`define MDR_OFS_IPD        8'h19
`define MDR_OFS_SUPPLY     8'h1A
`define MDR_OFS_CMD        8'h1B
`define MDR_OFS_APPLIED    8'h1C
`define MDR_OFS_FAULT      8'h1E

// ==========================================================================
// Field positions and reset values
`define MDR_ST_LSB         4
`define MDR_RST_BYTE       8'h00
`define MDR_RST_WORD       16'h0000
`define MDR_TACH_RST       1'b1

// ==========================================================================
// Timing
`define MDR_CLK_NS         10
`define MDR_TICK_NS        10000
`define MDR_TICK_CYC       (`MDR_TICK_NS / `MDR_CLK_NS)
`define MDR_TICKS_PER_S    100000
`define MDR_SPEED_SCALE    10
`define MDR_SPEED_NUM      (`MDR_SPEED_SCALE * `MDR_TICKS_PER_S)

`endif

// ===== design/mdr_pkg.sv
package mdr_pkg;

  // Register read request from the serial front end
  typedef struct packed {
    logic       stb;
    logic [7:0] addr;
  } mdr_rd_req_t;

  // Status flags in register bit order, msb first
  typedef struct packed {
    logic thermal_fault_flag;
    logic sleep_flag;
    logic excess_current_flag;
    logic rotor_stall_flag;
  } mdr_status_t;

  typedef enum logic [1:0] {
    MDR_DIV_IDLE = 2'b01,
    MDR_DIV_RUN  = 2'b10
  } mdr_div_state_t;

endpackage : mdr_pkg

// ===== design/mdr_tach.sv
`timescale 1ns/1ps
`include "mdr_regs.svh"

module mdr_tach
  import mdr_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_comm_toggle,
  input  wire logic       i_open_loop,
  input  wire logic       i_locked,
  input  wire logic       i_start,
  input  wire logic [1:0] i_ol_sel,
  output logic            o_tach
);

  logic seen_start_q;
  logic restart_q;
  logic ol_follow;

  // Any start after the first since reset counts as a restart
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      seen_start_q <= 1'b0;
      restart_q    <= 1'b0;
    end
    else if (i_start)
    begin
      seen_start_q <= 1'b1;
      restart_q    <= seen_start_q;
    end
  end

  assign ol_follow = (i_ol_sel == 2'd0) ||
                     ((i_ol_sel == 2'd2) && !restart_q);

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_tach <= `MDR_TACH_RST;
    else if (i_locked)
      o_tach <= 1'b1;
    else if (i_open_loop && !ol_follow)
      o_tach <= 1'b1;
    else if (i_comm_toggle)
      o_tach <= ~o_tach;
  end

  property p_lock_high;
    @(posedge i_clock) disable iff (!i_rst_n)
    i_locked |=> o_tach;
  endproperty
  a_lock_high: assert property (p_lock_high)
    else $error("tach not high while locked");

  property p_ol_keep_high;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_open_loop && !i_locked && i_ol_sel == 2'd1) ##1
    (i_open_loop && !i_locked && i_ol_sel == 2'd1) |-> o_tach;
  endproperty
  a_ol_keep_high: assert property (p_ol_keep_high)
    else $error("tach toggled in hold-high open loop");

  property p_cl_toggle;
    @(posedge i_clock) disable iff (!i_rst_n)
    (!i_locked && !i_open_loop && i_comm_toggle) |=>
      (o_tach != $past(o_tach));
  endproperty
  a_cl_toggle: assert property (p_cl_toggle)
    else $error("tach missed a commutation toggle");

endmodule : mdr_tach

// ===== design/mdr_period.sv
`timescale 1ns/1ps
`include "mdr_regs.svh"

module mdr_period
  import mdr_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_spinning,
  input  wire logic        i_zc_u,
  output logic [15:0]      o_period,
  output logic [15:0]      o_speed
);

  localparam logic [9:0]  TICK_LAST = 10'(`MDR_TICK_CYC - 1);
  localparam logic [19:0] SPD_NUM   = 20'(`MDR_SPEED_NUM);

  logic [9:0]     pre_q;
  logic [15:0]    cnt_q;
  logic [19:0]    num_q;
  logic [19:0]    quo_q;
  logic [16:0]    rem_q;
  logic [16:0]    rem_sh;
  logic [4:0]     bit_q;
  mdr_div_state_t st_q;
  logic           capture;

  assign capture = i_zc_u && i_spinning;
  assign rem_sh  = {rem_q[15:0], num_q[19]};

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pre_q    <= 10'h000;
      cnt_q    <= `MDR_RST_WORD;
      o_period <= `MDR_RST_WORD;
    end
    else
    begin
      pre_q <= (pre_q == TICK_LAST || i_zc_u) ? 10'h000 : pre_q + 10'h001;
      if (i_zc_u)
        cnt_q <= `MDR_RST_WORD;
      else if (pre_q == TICK_LAST && cnt_q != 16'hFFFF)
        cnt_q <= cnt_q + 16'h0001;
      if (capture)
        o_period <= cnt_q;
    end
  end

  // speed = 10 * 1e5 / period
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_q    <= MDR_DIV_IDLE;
      num_q   <= 20'h00000;
      quo_q   <= 20'h00000;
      rem_q   <= 17'h00000;
      bit_q   <= 5'h00;
      o_speed <= `MDR_RST_WORD;
    end
    else
    begin
      case (st_q)
        MDR_DIV_IDLE:
        begin
          if (capture)
          begin
            num_q <= SPD_NUM;
            quo_q <= 20'h00000;
            rem_q <= 17'h00000;
            bit_q <= 5'h00;
            st_q  <= MDR_DIV_RUN;
          end
        end
        MDR_DIV_RUN:
        begin
          num_q <= {num_q[18:0], 1'b0};
          if (rem_sh >= {1'b0, o_period})
          begin
            rem_q <= rem_sh - {1'b0, o_period};
            quo_q <= {quo_q[18:0], 1'b1};
          end
          else
          begin
            rem_q <= rem_sh;
            quo_q <= {quo_q[18:0], 1'b0};
          end
          bit_q <= bit_q + 5'h01;
          if (bit_q == 5'd19)
            st_q <= MDR_DIV_IDLE;
        end
        default: st_q <= MDR_DIV_IDLE;
      endcase
      if (st_q == MDR_DIV_RUN && bit_q == 5'd20)
        o_speed <= o_speed;
      if (st_q == MDR_DIV_IDLE && bit_q == 5'd20)
      begin
        o_speed <= (quo_q[19:16] != 4'h0) ? 16'hFFFF : quo_q[15:0];
        bit_q   <= 5'h00;
      end
    end
  end

  property p_period_capture;
    @(posedge i_clock) disable iff (!i_rst_n)
    capture |=> (o_period == $past(cnt_q));
  endproperty
  a_period_capture: assert property (p_period_capture)
    else $error("period not captured at zero crossing");

endmodule : mdr_period

// ===== design/mdr_readback.sv
`timescale 1ns/1ps
`include "mdr_regs.svh"

// Summary of operation
// - Locked rotor forces tach output high.
// - Open-loop tach per two-bit select option.
// - Status shows thermal, sleep, current, stall flags.
// - Speed refreshed while spinning, high/low bytes.
// - Speed equals ten times electrical frequency.
// - High-byte read snapshots low byte for later.
// - Period in 10 us units between crossings.
// - BEMF integrated per cycle into two bytes.
// - Position code in 60-degree steps.
// - Stored code adds advance code modulo 256.
// - Supply sampled periodically into 8-bit code.
// - Speed command converted, 255 is full.
// - Applied code is limited output duty.
// - Readback follows its sources, low bytes from the high-read snapshot; readable any time.
// - Read-only registers at 0x10 to 0x1E.
module mdr_readback
  import mdr_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire mdr_rd_req_t i_rd,
  output logic [7:0]       o_rd_data,
  output logic             o_rd_valid,
  input  wire mdr_status_t i_status,
  input  wire logic        i_spinning,
  input  wire logic        i_zc_u,
  input  wire logic        i_bemf_vld,
  input  wire logic [11:0] i_bemf_mag,
  input  wire logic [10:0] i_current,
  input  wire logic        i_ipd_done,
  input  wire logic [2:0]  i_ipd_sector,
  input  wire logic [1:0]  i_ipd_adv_sel,
  input  wire logic        i_supply_vld,
  input  wire logic [7:0]  i_supply_code,
  input  wire logic [1:0]  i_cmd_src,
  input  wire logic [7:0]  i_pwm_duty,
  input  wire logic [7:0]  i_analog_code,
  input  wire logic [8:0]  i_i2c_speed,
  input  wire logic        i_limit_en,
  input  wire logic [7:0]  i_duty_limit,
  input  wire logic [5:0]  i_fault_code,
  input  wire logic        i_comm_toggle,
  input  wire logic        i_open_loop,
  input  wire logic        i_start,
  input  wire logic [1:0]  i_ol_sel,
  output logic             o_tach
);

  // ========================================================================
  // Helpers

  // Pair index of a two-byte register; bit 2 flags a hit
  function automatic logic [2:0] mdr_pair_of(input logic [7:0] hi_addr);
    case (hi_addr)
      `MDR_OFS_SPEED_HI:  mdr_pair_of = 3'b100;
      `MDR_OFS_PERIOD_HI: mdr_pair_of = 3'b101;
      `MDR_OFS_KT_HI:     mdr_pair_of = 3'b110;
      `MDR_OFS_CURR_HI:   mdr_pair_of = 3'b111;
      default:            mdr_pair_of = 3'b000;
    endcase
  endfunction : mdr_pair_of

  // Rotor sector to position code
  function automatic logic [7:0] mdr_sector_code(input logic [2:0] sec);
    case (sec)
      3'd1:    mdr_sector_code = 8'h2B;
      3'd2:    mdr_sector_code = 8'h55;
      3'd3:    mdr_sector_code = 8'h80;
      3'd4:    mdr_sector_code = 8'hAB;
      3'd5:    mdr_sector_code = 8'hD5;
      default: mdr_sector_code = 8'h00;
    endcase
  endfunction : mdr_sector_code

  // Advance angle to advance code
  function automatic logic [7:0] mdr_adv_code(input logic [1:0] sel);
    case (sel)
      2'd0:    mdr_adv_code = 8'h16;
      2'd1:    mdr_adv_code = 8'h2C;
      2'd2:    mdr_adv_code = 8'h3F;
      default: mdr_adv_code = 8'h55;
    endcase
  endfunction : mdr_adv_code

  // ========================================================================
  // Measured values

  logic [15:0] period_w;
  logic [15:0] speed_w;
  logic [19:0] kt_acc_q;
  logic [20:0] kt_sum;
  logic [15:0] kt_q;
  logic [7:0]  ipd_q;
  logic [7:0]  supply_q;
  logic [7:0]  cmd_q;
  logic [7:0]  applied_q;
  logic [15:0] live [4];
  logic [7:0]  snap_q [4];
  logic [2:0]  pair;
  logic [7:0]  rd_mux;

  mdr_period u_period (
    .i_clock    (i_clock),
    .i_rst_n    (i_rst_n),
    .i_spinning (i_spinning),
    .i_zc_u     (i_zc_u),
    .o_period   (period_w),
    .o_speed    (speed_w)
  );

  mdr_tach u_tach (
    .i_clock       (i_clock),
    .i_rst_n       (i_rst_n),
    .i_comm_toggle (i_comm_toggle),
    .i_open_loop   (i_open_loop),
    .i_locked      (i_status.rotor_stall_flag),
    .i_start       (i_start),
    .i_ol_sel      (i_ol_sel),
    .o_tach        (o_tach)
  );

  // Saturate instead of wrapping so a long cycle reads full scale
  assign kt_sum = {1'b0, kt_acc_q} + {9'h000, i_bemf_mag};

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      kt_acc_q <= 20'h00000;
      kt_q     <= `MDR_RST_WORD;
    end
    else if (i_zc_u && i_spinning)
    begin
      kt_acc_q <= i_bemf_vld ? {8'h00, i_bemf_mag} : 20'h00000;
      kt_q     <= (kt_acc_q[19:16] != 4'h0) ? 16'hFFFF : kt_acc_q[15:0];
    end
    else if (i_bemf_vld && i_spinning)
      kt_acc_q <= kt_sum[20] ? 20'hFFFFF : kt_sum[19:0];
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ipd_q <= `MDR_RST_BYTE;
    else if (i_ipd_done)
      ipd_q <= mdr_sector_code(i_ipd_sector) + mdr_adv_code(i_ipd_adv_sel);
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      supply_q <= `MDR_RST_BYTE;
    else if (i_supply_vld)
      supply_q <= i_supply_code;
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cmd_q <= `MDR_RST_BYTE;
    else
    begin
      case (i_cmd_src)
        2'd0:    cmd_q <= i_pwm_duty;
        2'd1:    cmd_q <= i_analog_code;
        default: cmd_q <= (i_i2c_speed[8:1] == 8'hFF || i_i2c_speed[8])
                          ? 8'hFF : i_i2c_speed[7:0];
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      applied_q <= `MDR_RST_BYTE;
    else if (i_limit_en && i_duty_limit < cmd_q)
      applied_q <= i_duty_limit;
    else
      applied_q <= cmd_q;
  end

  assign live[0] = speed_w;
  assign live[1] = period_w;
  assign live[2] = kt_q;
  assign live[3] = {5'h00, i_current};

  // ========================================================================
  // Read port

  assign pair = mdr_pair_of(i_rd.addr);

  // snapshot on high read, held until next
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < 4; i++)
        snap_q[i] <= `MDR_RST_BYTE;
    end
    else if (i_rd.stb && pair[2])
      snap_q[pair[1:0]] <= live[pair[1:0]][7:0];
  end

  always_comb
  begin
    rd_mux = `MDR_RST_BYTE;
    case (i_rd.addr)
      `MDR_OFS_STATUS:    rd_mux = {i_status, 4'h0};
      `MDR_OFS_SPEED_HI:  rd_mux = live[0][15:8];
      `MDR_OFS_SPEED_LO:  rd_mux = snap_q[0];
      `MDR_OFS_PERIOD_HI: rd_mux = live[1][15:8];
      `MDR_OFS_PERIOD_LO: rd_mux = snap_q[1];
      `MDR_OFS_KT_HI:     rd_mux = live[2][15:8];
      `MDR_OFS_KT_LO:     rd_mux = snap_q[2];
      `MDR_OFS_CURR_HI:   rd_mux = live[3][15:8];
      `MDR_OFS_CURR_LO:   rd_mux = snap_q[3];
      `MDR_OFS_IPD:       rd_mux = ipd_q;
      `MDR_OFS_SUPPLY:    rd_mux = supply_q;
      `MDR_OFS_CMD:       rd_mux = cmd_q;
      `MDR_OFS_APPLIED:   rd_mux = applied_q;
      `MDR_OFS_FAULT:     rd_mux = {2'b00, i_fault_code};
      default:            rd_mux = `MDR_RST_BYTE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rd_data  <= `MDR_RST_BYTE;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= i_rd.stb;
      if (i_rd.stb)
        o_rd_data <= rd_mux;
    end
  end

  // ========================================================================
  // Checks

  property p_snap_hold;
    @(posedge i_clock) disable iff (!i_rst_n)
    !(i_rd.stb && i_rd.addr == `MDR_OFS_SPEED_HI) |=> $stable(snap_q[0]);
  endproperty
  a_snap_hold: assert property (p_snap_hold)
    else $error("speed snapshot changed without a high read");

  property p_snap_take;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_rd.stb && i_rd.addr == `MDR_OFS_PERIOD_HI) |=>
      (snap_q[1] == $past(period_w[7:0]));
  endproperty
  a_snap_take: assert property (p_snap_take)
    else $error("period low byte not captured on high read");

  property p_lo_read;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_rd.stb && i_rd.addr == `MDR_OFS_SPEED_LO) |=>
      (o_rd_valid && o_rd_data == $past(snap_q[0]));
  endproperty
  a_lo_read: assert property (p_lo_read)
    else $error("low byte read did not return the snapshot");

  property p_status;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_rd.stb && i_rd.addr == `MDR_OFS_STATUS) |=>
      (o_rd_data[7:4] == $past(i_status) && o_rd_data[3:0] == 4'h0);
  endproperty
  a_status: assert property (p_status)
    else $error("status readback wrong");

  property p_unmapped;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_rd.stb && (i_rd.addr < `MDR_OFS_STATUS ||
                  i_rd.addr > `MDR_OFS_FAULT ||
                  i_rd.addr == 8'h1D)) |=>
      (o_rd_valid && o_rd_data == 8'h00);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped address did not read zero");

  property p_ipd;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_ipd_done && i_ipd_sector == 3'd5 && i_ipd_adv_sel == 2'd3) |=>
      (ipd_q == 8'h2A);
  endproperty
  a_ipd: assert property (p_ipd)
    else $error("position code did not wrap modulo 256");

  property p_applied;
    @(posedge i_clock) disable iff (!i_rst_n)
    (!i_limit_en) |=> (applied_q == $past(cmd_q));
  endproperty
  a_applied: assert property (p_applied)
    else $error("applied code differs from command without limiting");

  property p_supply;
    @(posedge i_clock) disable iff (!i_rst_n)
    i_supply_vld ##1 !i_supply_vld |-> (supply_q == $past(i_supply_code));
  endproperty
  a_supply: assert property (p_supply)
    else $error("supply code not stored");

  property p_speed_take;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_rd.stb && i_rd.addr == `MDR_OFS_SPEED_HI) |=>
      (snap_q[0] == $past(speed_w[7:0]));
  endproperty
  a_speed_take: assert property (p_speed_take)
    else $error("speed low byte not captured on high read");

  property p_hi_read;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_rd.stb && i_rd.addr == `MDR_OFS_SPEED_HI) |=>
      (o_rd_valid && o_rd_data == $past(speed_w[15:8]));
  endproperty
  a_hi_read: assert property (p_hi_read)
    else $error("speed high byte read did not return the live value");

  property p_kt_store;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_zc_u && i_spinning && kt_acc_q[19:16] == 4'h0) |=>
      (kt_q == $past(kt_acc_q[15:0]));
  endproperty
  a_kt_store: assert property (p_kt_store)
    else $error("integrated value not stored at the crossing");

  property p_cmd_pwm;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_cmd_src == 2'd0) |=> (cmd_q == $past(i_pwm_duty));
  endproperty
  a_cmd_pwm: assert property (p_cmd_pwm)
    else $error("command code does not follow the duty input");

endmodule : mdr_readback

// ===== verif/mdr_host.sv
`timescale 1ns/1ps

module mdr_host
  import mdr_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_rd_valid,
  output mdr_rd_req_t     o_rd
);
  initial o_rd = '0;

  // ======================================================================
  // Reads start at a falling edge; the answer is taken a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    o_rd = '{stb: 1'b1, addr: a};
    @(negedge i_clock);
    // Idle address flips so a stale value cannot pass for a decode
    o_rd = '{stb: 1'b0, addr: ~a};
    d = i_rd_valid ? i_rd_data : 8'hXX;
    @(negedge i_clock);
  endtask : rd

  task automatic rd_pair(input logic [7:0] a, output logic [15:0] d);
    o_rd = '{stb: 1'b1, addr: a};
    @(negedge i_clock);
    o_rd.addr = a + 8'h01;
    d[15:8] = i_rd_valid ? i_rd_data : 8'hXX;
    @(negedge i_clock);
    o_rd = '{stb: 1'b0, addr: ~a};
    d[7:0] = i_rd_valid ? i_rd_data : 8'hXX;
    @(negedge i_clock);
  endtask : rd_pair
endmodule : mdr_host

// ===== verif/mdr_readback_test.sv
`timescale 1ns/1ps
`include "mdr_regs.svh"

module mdr_readback_test
  import mdr_pkg::*;
();
  logic        i_clock, i_rst_n, rd_valid, spinning, zc, bemf_vld;
  logic        ipd_done, supply_vld, limit_en, comm, open_loop, start, tach;
  mdr_rd_req_t rd;
  mdr_status_t status;
  logic [7:0]  rd_data, supply, pwm, analog, duty_lim, snap;
  logic [11:0] bemf_mag;
  logic [10:0] current;
  logic [8:0]  i2c_spd;
  logic [5:0]  fault;
  logic [2:0]  sector;
  logic [1:0]  adv, cmd_src, ol_sel;
  logic [15:0] w, kt;
  logic [7:0]  d, cmd;
  integer      seed = 30;
  int          error_cnt = 0, total_checks = 0, n;
  logic [7:0]  pos [6] = '{8'h00, 8'h2B, 8'h55, 8'h80, 8'hAB, 8'hD5};
  logic [7:0]  advc [4] = '{8'h16, 8'h2C, 8'h3F, 8'h55};

  mdr_readback dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_rd(rd),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .i_status(status),
    .i_spinning(spinning), .i_zc_u(zc), .i_bemf_vld(bemf_vld),
    .i_bemf_mag(bemf_mag), .i_current(current), .i_ipd_done(ipd_done),
    .i_ipd_sector(sector), .i_ipd_adv_sel(adv), .i_supply_vld(supply_vld),
    .i_supply_code(supply), .i_cmd_src(cmd_src), .i_pwm_duty(pwm),
    .i_analog_code(analog), .i_i2c_speed(i2c_spd), .i_limit_en(limit_en),
    .i_duty_limit(duty_lim), .i_fault_code(fault), .i_comm_toggle(comm),
    .i_open_loop(open_loop), .i_start(start), .i_ol_sel(ol_sel),
    .o_tach(tach));

  mdr_host host_u (.i_clock(i_clock), .i_rd_data(rd_data),
    .i_rd_valid(rd_valid), .o_rd(rd));

  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // ======================================================================
  // Expectations and comparisons
  function automatic logic [15:0] exp_speed(input int p);
    int q;
    q = (p == 0) ? 65536 : `MDR_SPEED_NUM / p;
    return (q > 65535) ? 16'hFFFF : 16'(q);
  endfunction : exp_speed

  function automatic logic [7:0] exp_cmd(input logic [1:0] s);
    if (s == 2'h0) return pwm;
    if (s == 2'h1) return analog;
    return (i2c_spd > 9'h0FF) ? 8'hFF : i2c_spd[7:0];
  endfunction : exp_cmd

  task automatic check_val(input string nm, input logic [15:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : check_val

  task automatic check_bit(input string nm, input logic e, g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask : check_bit

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // ======================================================================
  // Stimulus helpers
  task automatic tach_case(input logic ol, input logic [1:0] sel,
                           input logic stl, input logic cm, input logic e);
    open_loop = ol;
    ol_sel = sel;
    status.rotor_stall_flag = stl;
    comm = cm;
    @(negedge i_clock);
    comm = 1'b0;
    @(negedge i_clock);
    check_bit("tach", e, tach);
  endtask : tach_case

  task automatic pulse_start();
    start = 1'b1;
    @(negedge i_clock);
    start = 1'b0;
  endtask : pulse_start

  // Closes the previous interval, then times one of n ticks plus half
  task automatic measure(input int p);
    kt = 16'h0000;
    zc = 1'b1;
    @(negedge i_clock);
    zc = 1'b0;
    repeat (3)
    begin
      bemf_mag = 12'($random(seed));
      bemf_vld = 1'b1;
      kt += 16'(bemf_mag);
      @(negedge i_clock);
    end
    bemf_vld = 1'b0;
    repeat (p * `MDR_TICK_CYC + 500) @(negedge i_clock);
    zc = 1'b1;
    @(negedge i_clock);
    zc = 1'b0;
    repeat (30) @(negedge i_clock);
  endtask : measure

  initial
  begin
    #900000;
    error_cnt++;
    $display("watchdog expired");
    finish_test();
  end

  // ======================================================================
  // Main sequence
  initial
  begin
    {spinning, zc, bemf_vld, ipd_done, supply_vld, limit_en} = '0;
    {comm, open_loop, start, status, bemf_mag, current, sector} = '0;
    {adv, supply, cmd_src, pwm, analog, i2c_spd, duty_lim} = '0;
    {fault, ol_sel} = '0;
    i_rst_n = 1'b0;
    repeat (16) @(negedge i_clock);
    i_rst_n = 1'b1;
    for (int a = 0; a < 33; a++)
    begin
      host_u.rd(8'(a == 32 ? 255 : a), d);
      check_val("reset read", 16'h0000, 16'(d));
    end
    $display("test reset done");

    pulse_start();
    tach_case(1'b1, 2'h2, 1'b0, 1'b1, 1'b0);
    tach_case(1'b1, 2'h2, 1'b0, 1'b1, 1'b1);
    pulse_start();
    tach_case(1'b1, 2'h2, 1'b0, 1'b1, 1'b1);
    tach_case(1'b1, 2'h0, 1'b0, 1'b1, 1'b0);
    tach_case(1'b1, 2'h1, 1'b0, 1'b0, 1'b1);
    tach_case(1'b1, 2'h0, 1'b0, 1'b1, 1'b0);
    tach_case(1'b1, 2'h3, 1'b0, 1'b1, 1'b1);
    tach_case(1'b0, 2'h0, 1'b0, 1'b1, 1'b0);
    tach_case(1'b0, 2'h0, 1'b0, 1'b1, 1'b1);
    tach_case(1'b0, 2'h0, 1'b1, 1'b1, 1'b1);
    tach_case(1'b0, 2'h0, 1'b0, 1'b1, 1'b0);
    tach_case(1'b0, 2'h0, 1'b1, 1'b0, 1'b1);
    $display("test tach done");

    spinning = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      n = (i == 1) ? 2 : 16 + ({$random(seed)} % 7);
      measure(n);
      // period is the precise figure, speed is derived from it
      host_u.rd_pair(`MDR_OFS_PERIOD_HI, w);
      check_val("period", 16'(n), w);
      host_u.rd_pair(`MDR_OFS_KT_HI, w);
      check_val("bemf const", kt, w);
      if (i == 1)
      begin
        host_u.rd(`MDR_OFS_SPEED_LO, d);
        check_val("stale speed low", 16'(snap), 16'(d));
      end
      host_u.rd_pair(`MDR_OFS_SPEED_HI, w);
      check_val("speed", exp_speed(n), w);
      snap = 8'(exp_speed(n));
    end
    $display("test measure done");

    for (int i = 0; i < 24; i++)
    begin
      sector = 3'(i % 6);
      adv = 2'(i / 6);
      ipd_done = 1'b1;
      @(negedge i_clock);
      ipd_done = 1'b0;
      host_u.rd(`MDR_OFS_IPD, d);
      check_val("ipd", 16'(8'(pos[sector] + advc[adv])), 16'(d));
    end
    $display("test ipd done");

    for (int i = 0; i < 12; i++)
    begin
      {status, fault, current} = 21'($random(seed));
      {supply, pwm, analog, duty_lim} = 32'($random(seed));
      {i2c_spd, limit_en} = 10'($random(seed));
      cmd_src = 2'(i);
      supply_vld = 1'b1;
      @(negedge i_clock);
      supply_vld = 1'b0;
      repeat (3) @(negedge i_clock);
      cmd = exp_cmd(cmd_src);
      host_u.rd(`MDR_OFS_STATUS, d);
      check_val("status", 16'({status, 4'h0}), 16'(d));
      host_u.rd(`MDR_OFS_FAULT, d);
      check_val("fault", 16'({2'b00, fault}), 16'(d));
      host_u.rd_pair(`MDR_OFS_CURR_HI, w);
      check_val("current", 16'(current), w);
      host_u.rd(`MDR_OFS_SUPPLY, d);
      check_val("supply", 16'(supply), 16'(d));
      host_u.rd(`MDR_OFS_CMD, d);
      check_val("cmd", 16'(cmd), 16'(d));
      host_u.rd(`MDR_OFS_APPLIED, d);
      check_val("applied", 16'((limit_en && duty_lim < cmd) ? duty_lim
                : cmd), 16'(d));
    end
    $display("test live values done");

    // Mid-run reset: snapshots clear and the next start is a first start
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_clock);
    i_rst_n = 1'b1;
    host_u.rd(`MDR_OFS_SPEED_LO, d);
    check_val("snapshot after reset", 16'h0000, 16'(d));
    pulse_start();
    tach_case(1'b1, 2'h2, 1'b0, 1'b1, 1'b0);
    $display("test mid reset done");
    finish_test();
  end
endmodule : mdr_readback_test
